// ### common/ccs_regs.svh
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCS_OFS_CTRL4         8'h07
`define CCS_OFS_STAT1         8'h08

// ----------------------------------------
// charger_control_four fields and reset
// ----------------------------------------
`define CCS_C4_FORCE_DET      7
`define CCS_C4_HALF_RATE      6
`define CCS_C4_SW_OFF         5
`define CCS_C4_WARM_SEL       4
`define CCS_C4_OFF_DLY        3
`define CCS_C4_SW_RST_EN      2
`define CCS_C4_DGL_HI         1
`define CCS_C4_DGL_LO         0
`define CCS_C4_RESET          8'h4C
// bits that the watchdog also returns to default; the rest only follow register reset
`define CCS_C4_WDOG_MASK      8'hD4

// ----------------------------------------
// charger_status_one fields
// ----------------------------------------
`define CCS_S1_SRC_HI         7
`define CCS_S1_SRC_LO         5
`define CCS_SRC_NONE          3'h0
`define CCS_SRC_HOST_STD      3'h1
`define CCS_SRC_ADAPTOR       3'h2
`define CCS_SRC_OTG           3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CCS_CLK_PERIOD_PS     5000
`define CCS_SHIP_DLY_MS       12000
`define CCS_DGL0_US           128
`define CCS_DGL1_US           256
`define CCS_DGL2_US           1000
`define CCS_DGL3_US           2000
`define CCS_DGL_CYC(us)       (19'((us) * 1000000 / `CCS_CLK_PERIOD_PS))
`define CCS_WARM_LIMIT_MV     13'h1004

`endif

// ### common/ccs_pkg.sv
package ccs_pkg;

	// charge phase reported by the charger core
	typedef enum logic [1:0] {
		CCS_CHG_OFF,
		CCS_CHG_PRE,
		CCS_CHG_FAST,
		CCS_CHG_DONE
	} ccs_chg_phase_e;

	// analog comparator levels, asynchronous to sys_clk
	typedef struct packed {
		logic vbus_present;
		logic vbus_in_range;
		logic vbus_poor;
		logic therm_reg;
		logic vbat_below_sysmin;
		logic psel_high;
		logic cool_temp;
		logic warm_temp;
		logic in_dpm;
	} ccs_analog_s;

	// register access from the serial front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccs_reg_req_s;

	typedef enum logic {
		CCS_DET_IDLE,
		CCS_DET_RUN
	} ccs_det_state_e;

	typedef enum logic [1:0] {
		CCS_SW_ON,
		CCS_SW_WAIT,
		CCS_SW_OFF
	} ccs_sw_state_e;

endpackage

// ### rtl/ccs_regs.sv
`timescale 1ns/1ps
`include "ccs_regs.svh"

// Behaviour
// - force bit starts current limit detection with input present; clears itself when done
// - half-rate enable halves safety timer ticks during dpm, cool or thermal regulation
// - switch-off bit turns battery switch off, after ship-mode delay if selected
// - delay bit: 0 immediate turn-off, 1 delayed turn-off; default 1
// - warm band: charge to min(4.1 V, programmed) if bit 0, else programmed
// - battery switch reset enable bit allows reset when 1, default 1
// - filter field: 00 128us, 01 256us, 10 1ms, 11 2ms
// - control register resets to 0x4C
// - detecting variant reports detected source type code
// - base variant: none, host if select pin high, adaptor if low, otg
// - detected current limit goes to the current limit field
// - charge state reads 00 off, 01 pre, 10 fast, 11 terminated
// - power good reads 1 only while input in range and not poor
// - thermal flag reads 1 while in thermal regulation
// - system flag reads 1 while battery below minimum system voltage
// - register reset restores defaults, restarts safety timer, then clears
module ccs_regs #(
	parameter bit          HAS_DETECT   = 1'b1,
	parameter logic [31:0] SHIP_DLY_CYC = 32'(64'(`CCS_SHIP_DLY_MS) * 64'd1000000000 / 64'(`CCS_CLK_PERIOD_PS))
) (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	// register access
	input  wire ccs_pkg::ccs_reg_req_s    reg_req,
	output logic [7:0]                    reg_rdata_q,
	// reset sources
	input  wire logic                     reg_reset,
	input  wire logic                     watchdog_reset,
	// analog levels
	input  wire ccs_pkg::ccs_analog_s     analog_raw,
	// charger core
	input  wire ccs_pkg::ccs_chg_phase_e  charge_phase,
	input  wire logic                     otg_active,
	input  wire logic                     timer_base_tick,
	input  wire logic [12:0]              charge_reg_mv,
	// current limit detection
	input  wire logic                     det_done,
	input  wire logic [2:0]               det_type,
	input  wire logic [4:0]               det_ilim,
	output logic                          ilim_detect_start_q,
	output logic [4:0]                    input_current_limit_field_q,
	output logic                          ilim_field_load_q,
	// controls
	output logic                          safety_tick_q,
	output logic                          safety_timer_restart_q,
	output logic                          battery_switch_off_q,
	output logic                          battery_switch_reset_en_q,
	output logic [12:0]                   charge_target_mv_q,
	output logic [18:0]                   ocp_deglitch_cyc_q
);
	import ccs_pkg::*;

	localparam int NSYNC = $bits(ccs_analog_s);

	if (SHIP_DLY_CYC == 32'h0) begin : g_chk
		$error("SHIP_DLY_CYC must be at least one cycle");
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	ccs_analog_s      ana;

	for (genvar i = 0; i < NSYNC; i++) begin : g_sync
		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
			end else begin
				sync1_q[i] <= analog_raw[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end
	assign ana = ccs_analog_s'(sync2_q);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic [7:0]     ctrl_q;
	logic [7:0]     ctrl_d;
	ccs_det_state_e det_q;
	ccs_det_state_e det_d;
	logic           det_clear;
	logic           ctrl_wr;
	logic           stat_sel;
	logic [7:0]     ctrl_after_wr;
	logic [7:0]     ctrl_after_wd;

	assign ctrl_wr  = reg_req.wr && (reg_req.addr == `CCS_OFS_CTRL4);
	assign stat_sel = reg_req.addr == `CCS_OFS_STAT1;
	// a host write lands over a completing detection, so a fresh request is never lost
	assign ctrl_after_wr = ctrl_wr ?
		{reg_req.wdata[`CCS_C4_FORCE_DET] & ana.vbus_present, reg_req.wdata[6:0]} :
		{ctrl_q[`CCS_C4_FORCE_DET] & ~det_clear, ctrl_q[6:0]};
	assign ctrl_after_wd = watchdog_reset ?
		((ctrl_after_wr & ~`CCS_C4_WDOG_MASK) | (`CCS_C4_RESET & `CCS_C4_WDOG_MASK)) : ctrl_after_wr;
	assign ctrl_d = reg_reset ? `CCS_C4_RESET : ctrl_after_wd;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_q <= `CCS_C4_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------
	// current limit detection
	// ----------------------------------------
	logic [2:0] det_type_q;

	always_comb begin
		det_d     = det_q;
		det_clear = 1'b0;
		unique case (det_q)
			CCS_DET_IDLE: begin
				if (ctrl_q[`CCS_C4_FORCE_DET] && ana.vbus_present) begin
					det_d = CCS_DET_RUN;
				end
			end
			CCS_DET_RUN: begin
				// losing the input aborts the run, otherwise the bit would stick high
				if (det_done || !ana.vbus_present) begin
					det_d     = CCS_DET_IDLE;
					det_clear = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			det_q                       <= CCS_DET_IDLE;
			ilim_detect_start_q         <= 1'b0;
			ilim_field_load_q           <= 1'b0;
			input_current_limit_field_q <= 5'h00;
			det_type_q                  <= `CCS_SRC_NONE;
		end else begin
			det_q               <= det_d;
			ilim_detect_start_q <= (det_q == CCS_DET_IDLE) && (det_d == CCS_DET_RUN);
			ilim_field_load_q   <= (det_q == CCS_DET_RUN) && det_done;
			if ((det_q == CCS_DET_RUN) && det_done) begin
				input_current_limit_field_q <= det_ilim;
				det_type_q                  <= det_type;
			end
		end
	end

	// ----------------------------------------
	// safety timer rate
	// ----------------------------------------
	logic slow_cond;
	logic half_phase_q;

	assign slow_cond = ctrl_q[`CCS_C4_HALF_RATE] && (ana.in_dpm || ana.cool_temp || ana.therm_reg);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			half_phase_q           <= 1'b0;
			safety_tick_q          <= 1'b0;
			safety_timer_restart_q <= 1'b0;
		end else begin
			half_phase_q           <= slow_cond && (half_phase_q ^ timer_base_tick);
			safety_tick_q          <= timer_base_tick && (!slow_cond || half_phase_q);
			safety_timer_restart_q <= reg_reset;
		end
	end

	// ----------------------------------------
	// battery switch turn-off
	// ----------------------------------------
	ccs_sw_state_e sw_q;
	ccs_sw_state_e sw_d;
	logic [31:0]   sw_cnt_q;
	logic          sw_cnt_end;

	assign sw_cnt_end = sw_cnt_q == SHIP_DLY_CYC - 32'h1;

	always_comb begin
		sw_d = sw_q;
		unique case (sw_q)
			CCS_SW_ON: begin
				if (ctrl_q[`CCS_C4_SW_OFF]) begin
					sw_d = ctrl_q[`CCS_C4_OFF_DLY] ? CCS_SW_WAIT : CCS_SW_OFF;
				end
			end
			CCS_SW_WAIT: begin
				// clearing the bit during the wait cancels the pending turn-off
				if (!ctrl_q[`CCS_C4_SW_OFF]) begin
					sw_d = CCS_SW_ON;
				end else if (sw_cnt_end) begin
					sw_d = CCS_SW_OFF;
				end
			end
			CCS_SW_OFF: begin
				if (!ctrl_q[`CCS_C4_SW_OFF]) begin
					sw_d = CCS_SW_ON;
				end
			end
			default: begin
				sw_d = CCS_SW_ON;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sw_q                 <= CCS_SW_ON;
			sw_cnt_q             <= 32'h0000_0000;
			battery_switch_off_q <= 1'b0;
		end else begin
			sw_q                 <= sw_d;
			sw_cnt_q             <= (sw_q == CCS_SW_WAIT) ? sw_cnt_q + 32'h1 : 32'h0000_0000;
			battery_switch_off_q <= sw_d == CCS_SW_OFF;
		end
	end

	// ----------------------------------------
	// steering outputs
	// ----------------------------------------
	logic        warm_clamp;
	logic [18:0] dgl_cyc;

	assign warm_clamp = ana.warm_temp && !ctrl_q[`CCS_C4_WARM_SEL] && (charge_reg_mv > `CCS_WARM_LIMIT_MV);
	assign dgl_cyc =
		(ctrl_q[1:0] == 2'b00) ? `CCS_DGL_CYC(`CCS_DGL0_US) :
		(ctrl_q[1:0] == 2'b01) ? `CCS_DGL_CYC(`CCS_DGL1_US) :
		(ctrl_q[1:0] == 2'b10) ? `CCS_DGL_CYC(`CCS_DGL2_US) : `CCS_DGL_CYC(`CCS_DGL3_US);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			battery_switch_reset_en_q <= 1'b1;
			charge_target_mv_q        <= 13'h0000;
			ocp_deglitch_cyc_q        <= `CCS_DGL_CYC(`CCS_DGL0_US);
		end else begin
			battery_switch_reset_en_q <= ctrl_q[`CCS_C4_SW_RST_EN];
			charge_target_mv_q        <= warm_clamp ? `CCS_WARM_LIMIT_MV : charge_reg_mv;
			ocp_deglitch_cyc_q        <= dgl_cyc;
		end
	end

	// ----------------------------------------
	// status register and read data
	// ----------------------------------------
	logic [2:0] src_type;
	logic [7:0] status_w;
	logic [7:0] rd_mux;

	// the base variant has no detector, so with input present and otg off the select pin names the source
	assign src_type = otg_active ? `CCS_SRC_OTG :
		!ana.vbus_present ? `CCS_SRC_NONE :
		HAS_DETECT ? det_type_q :
		ana.psel_high ? `CCS_SRC_HOST_STD : `CCS_SRC_ADAPTOR;
	assign status_w = {src_type, charge_phase,
		ana.vbus_in_range & ~ana.vbus_poor,
		ana.therm_reg,
		ana.vbat_below_sysmin};
	assign rd_mux = (reg_req.addr == `CCS_OFS_CTRL4) ? ctrl_q : stat_sel ? status_w : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= reg_req.rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_force_done_clear: assert property (
		(det_q == CCS_DET_RUN) && det_done && !ctrl_wr && !reg_reset |=> !ctrl_q[`CCS_C4_FORCE_DET])
		else $error("force bit not cleared after detection");
	a_force_start: assert property (
		ctrl_wr && reg_req.wdata[7] && ana.vbus_present && !reg_reset && !watchdog_reset
		|=> ##[1:2] ilim_detect_start_q || (det_q == CCS_DET_RUN))
		else $error("detection not started");
	a_half_rate_skip: assert property (
		timer_base_tick && slow_cond && !half_phase_q |=> !safety_tick_q)
		else $error("safety tick not halved");
	a_full_rate_tick: assert property (
		timer_base_tick && !slow_cond |=> safety_tick_q)
		else $error("safety tick missing at full rate");
	a_switch_immediate: assert property (
		(sw_q == CCS_SW_ON) && ctrl_q[`CCS_C4_SW_OFF] && !ctrl_q[`CCS_C4_OFF_DLY] |=> battery_switch_off_q)
		else $error("immediate turn-off missed");
	a_switch_delay: assert property (
		$rose(battery_switch_off_q) |-> ($past(sw_q) == CCS_SW_ON) || $past(sw_cnt_end))
		else $error("battery switch off before ship-mode delay");
	a_warm_clamp: assert property (
		ana.warm_temp && !ctrl_q[`CCS_C4_WARM_SEL] |=> charge_target_mv_q <= `CCS_WARM_LIMIT_MV)
		else $error("warm charge voltage above limit");
	a_reg_reset_value: assert property (
		reg_reset |=> (ctrl_q == `CCS_C4_RESET) ##1 battery_switch_reset_en_q && safety_timer_restart_q == 1'b0)
		else $error("register reset did not restore defaults");
	a_restart_pulse: assert property (
		reg_reset |=> safety_timer_restart_q)
		else $error("safety timer restart missing");
	a_deglitch_sel: assert property (
		ctrl_q[1:0] == 2'b11 |=> ocp_deglitch_cyc_q == 19'd400000)
		else $error("deglitch count wrong");
	a_src_otg: assert property (
		reg_req.rd && stat_sel && otg_active |=> reg_rdata_q[7:5] == `CCS_SRC_OTG)
		else $error("otg source not reported");
	a_status_flags: assert property (
		reg_req.rd && stat_sel |=> reg_rdata_q[4:0] ==
			{$past(charge_phase), $past(ana.vbus_in_range & ~ana.vbus_poor), $past(ana.therm_reg),
			$past(ana.vbat_below_sysmin)})
		else $error("status flags wrong");

	a_base_source: assert property (
		!HAS_DETECT && reg_req.rd && stat_sel && !otg_active && ana.vbus_present
		|=> reg_rdata_q[7:5] == ($past(ana.psel_high) ? `CCS_SRC_HOST_STD : `CCS_SRC_ADAPTOR))
		else $error("base variant source wrong");
	a_limit_load: assert property (
		(det_q == CCS_DET_RUN) && det_done
		|=> ilim_field_load_q && (input_current_limit_field_q == $past(det_ilim)))
		else $error("detected current limit not loaded");
	a_force_no_input: assert property (
		ctrl_wr && !ana.vbus_present |=> !ctrl_q[`CCS_C4_FORCE_DET])
		else $error("force bit stored without input");
	a_ship_cancel: assert property (
		(sw_q == CCS_SW_WAIT) && !ctrl_q[`CCS_C4_SW_OFF] |=> !battery_switch_off_q)
		else $error("cancelled turn-off still taken");
	a_warm_free: assert property (
		!ana.warm_temp |=> charge_target_mv_q == $past(charge_reg_mv))
		else $error("charge voltage clamped outside warm band");
	a_wdog_keep: assert property (
		watchdog_reset && !reg_reset && !ctrl_wr
		|=> ctrl_q == (($past(ctrl_q) & ~`CCS_C4_WDOG_MASK) | (`CCS_C4_RESET & `CCS_C4_WDOG_MASK)))
		else $error("watchdog reset changed the wrong bits");

	c_detect_done: cover property ((det_q == CCS_DET_RUN) && det_done);
	c_ship_wait: cover property ((sw_q == CCS_SW_WAIT) ##1 (sw_q == CCS_SW_WAIT));
	c_slow_tick: cover property (timer_base_tick && slow_cond ##[1:20] safety_tick_q);
	c_status_read: cover property (reg_req.rd && stat_sel);

endmodule

// ### dv/ccs_det_model.sv
`timescale 1ns/1ps
// current limit detector model; answers after a programmable number of cycles
module ccs_det_model (
	// clock
	input  wire logic       sys_clk,
	// request and result to return
	input  wire logic       start,
	input  wire logic [7:0] dly,
	input  wire logic [2:0] res_type,
	input  wire logic [4:0] res_ilim,
	// answer
	output logic            done,
	output logic [2:0]      dtype,
	output logic [4:0]      dilim
);
	int cnt = -1;
	initial begin
		done = 1'b0;
		dtype = 3'h0;
		dilim = 5'h00;
	end
	// results count only with done; between answers they toggle so stale values never match
	always @(posedge sys_clk) begin
		done <= (cnt == 0);
		dtype <= (cnt == 0) ? res_type : ~dtype;
		dilim <= (cnt == 0) ? res_ilim : ~dilim;
		if (start)
			cnt <= int'(dly);
		else if (cnt >= 0)
			cnt <= cnt - 1;
	end
endmodule

// ### dv/test_charger_control_status_regs.sv
`timescale 1ns/1ps
`include "ccs_regs.svh"
module test_charger_control_status_regs;
	import ccs_pkg::*;
	localparam int SHIP = 20;
	logic                sys_clk = 1'b0;
	logic                rst_n = 1'b0;
	ccs_reg_req_s        req = '0;
	logic                reg_reset = 1'b0;
	logic                wd_reset = 1'b0;
	ccs_analog_s         ana = '0;
	ccs_chg_phase_e      phase = CCS_CHG_OFF;
	logic                otg = 1'b0;
	logic                base_tick = 1'b0;
	logic [12:0]         charge_regulation_voltage_mv = 13'h1068;
	logic [2:0]          res_type = 3'h0;
	logic [4:0]          res_ilim = 5'h00;
	logic [7:0]          dly = 8'h01;
	logic [7:0]          rdata;
	logic [7:0]          rdata_b;
	logic                det_done, det_start, fld_load, s_tick, t_restart, sw_off, sw_rst_en;
	logic [2:0]          det_type;
	logic [4:0]          det_ilim, ilim_fld;
	logic [12:0]         tgt_mv;
	logic [18:0]         dgl_cyc;
	logic [2:0]          codes[5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
	int                  dgl_us[4] = '{128, 256, 1000, 2000};
	int                  err_total = 0;
	int                  tests_run = 0;
	int                  ticks = 0;
	int                  ctl = 'h4C;
	int                  src = 0;
	int                  v;

	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (s_tick) ticks++;

	ccs_regs #(
		.HAS_DETECT  (1'b1),
		.SHIP_DLY_CYC(32'(SHIP))
	) u_dut (
		.sys_clk                    (sys_clk),
		.rst_n                      (rst_n),
		.reg_req                    (req),
		.reg_rdata_q                (rdata),
		.reg_reset                  (reg_reset),
		.watchdog_reset             (wd_reset),
		.analog_raw                 (ana),
		.charge_phase               (phase),
		.otg_active                 (otg),
		.timer_base_tick            (base_tick),
		.charge_reg_mv              (charge_regulation_voltage_mv),
		.det_done                   (det_done),
		.det_type                   (det_type),
		.det_ilim                   (det_ilim),
		.ilim_detect_start_q        (det_start),
		.input_current_limit_field_q(ilim_fld),
		.ilim_field_load_q          (fld_load),
		.safety_tick_q              (s_tick),
		.safety_timer_restart_q     (t_restart),
		.battery_switch_off_q       (sw_off),
		.battery_switch_reset_en_q  (sw_rst_en),
		.charge_target_mv_q         (tgt_mv),
		.ocp_deglitch_cyc_q         (dgl_cyc)
	);

	ccs_regs #(
		.HAS_DETECT  (1'b0),
		.SHIP_DLY_CYC(32'(SHIP))
	) u_base (
		.sys_clk                    (sys_clk),
		.rst_n                      (rst_n),
		.reg_req                    (req),
		.reg_rdata_q                (rdata_b),
		.reg_reset                  (reg_reset),
		.watchdog_reset             (wd_reset),
		.analog_raw                 (ana),
		.charge_phase               (phase),
		.otg_active                 (otg),
		.timer_base_tick            (base_tick),
		.charge_reg_mv              (charge_regulation_voltage_mv),
		.det_done                   (det_done),
		.det_type                   (det_type),
		.det_ilim                   (det_ilim),
		.ilim_detect_start_q        (),
		.input_current_limit_field_q(),
		.ilim_field_load_q          (),
		.safety_tick_q              (),
		.safety_timer_restart_q     (),
		.battery_switch_off_q       (),
		.battery_switch_reset_en_q  (),
		.charge_target_mv_q         (),
		.ocp_deglitch_cyc_q         ()
	);

	ccs_det_model u_det (
		.sys_clk (sys_clk),
		.start   (det_start),
		.dly     (dly),
		.res_type(res_type),
		.res_ilim(res_ilim),
		.done    (det_done),
		.dtype   (det_type),
		.dilim   (det_ilim)
	);

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		cyc(1);
		req.wr = 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		req.rd = 1'b1;
		req.addr = a;
		cyc(1);
		req.rd = 1'b0;
		chk(19'(rdata), 19'(exp));
	endtask
	function automatic logic [7:0] stat_exp();
		logic [2:0] s;
		s = otg ? 3'h7 : (ana.vbus_present ? 3'(src) : 3'h0);
		return {s, 2'(phase), ana.vbus_in_range & ~ana.vbus_poor, ana.therm_reg, ana.vbat_below_sysmin};
	endfunction
	// base variant: no detector, the select pin names the source
	function automatic logic [7:0] base_exp();
		logic [7:0] f;
		f = stat_exp();
		f[7:5] = otg ? 3'h7 : (!ana.vbus_present ? 3'h0 : (ana.psel_high ? 3'h1 : 3'h2));
		return f;
	endfunction
	task automatic report_and_stop();
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		report_and_stop();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		v = $urandom(32'h0000_ce2e);
		cyc(16);
		rst_n = 1'b1;
		rd(8'h07, 8'h4C);
		chk(19'(sw_rst_en), 19'h1);
		for (int m = 0; m < 3; m++) begin
			{ana.cool_temp, ana.in_dpm} = (m == 1) ? 2'b10 : 2'b01;
			cyc(3);
			ticks = 0;
			repeat (4) begin
				base_tick = 1'b1;
				cyc(1);
				base_tick = 1'b0;
				cyc(2);
			end
			chk(19'(ticks), (m == 2) ? 19'h4 : 19'h2);
			if (m == 1)
				wr(8'h07, 8'h0C);
		end
		for (int i = 0; i < 4; i++) begin
			ctl = 'h48 | i;
			wr(8'h07, 8'(ctl));
			cyc(2);
			chk(dgl_cyc, 19'(dgl_us[i] * 200));
			chk(19'(sw_rst_en), 19'h0);
			rd(8'h07, 8'(ctl));
		end
		ana.warm_temp = 1'b1;
		for (int w = 0; w < 2; w++) begin
			charge_regulation_voltage_mv = 13'($urandom_range(3856, 4624));
			wr(8'h07, 8'(ctl | (w << 4)));
			cyc(4);
			chk(19'(tgt_mv), 19'((w || charge_regulation_voltage_mv < 4100) ? charge_regulation_voltage_mv : 13'h1004));
		end
		ana.warm_temp = 1'b0;
		ctl = ctl | 'h10;
		ana.vbus_present = 1'b1;
		ana.vbus_in_range = 1'b1;
		cyc(3);
		for (int k = 0; k < 5; k++) begin
			res_type = codes[k];
			res_ilim = 5'($urandom);
			dly = k[0] ? 8'h1e : 8'h01;
			wr(8'h07, 8'(ctl | 'h80));
			for (int t = 0; t < 60 && fld_load !== 1'b1; t++) @(negedge sys_clk);
			chk(19'(fld_load), 19'h1);
			chk(19'(ilim_fld), 19'(res_ilim));
			src = res_type;
			rd(8'h07, 8'(ctl));
			{otg, ana.vbus_in_range, ana.vbus_poor, ana.therm_reg, ana.vbat_below_sysmin, ana.psel_high} = 6'($urandom);
			phase = ccs_chg_phase_e'(k[1:0] + 2'(k >> 2));
			cyc(3);
			rd(8'h08, stat_exp());
			chk(19'(rdata_b), 19'(base_exp()));
			otg = 1'b0;
		end
		for (int d = 0; d < 2; d++) begin
			wr(8'h07, d ? 8'h28 : 8'h20);
			cyc(d ? SHIP - 3 : 2);
			chk(19'(sw_off), d ? 19'h0 : 19'h1);
			cyc(8);
			chk(19'(sw_off), 19'h1);
			wr(8'h07, 8'h0C);
		end
		// watchdog restores bits 7,6,4,2 and keeps the rest
		wr(8'h07, 8'h7F);
		wd_reset = 1'b1;
		cyc(1);
		wd_reset = 1'b0;
		rd(8'h07, 8'h6F);
		reg_reset = 1'b1;
		cyc(1);
		reg_reset = 1'b0;
		chk(19'(t_restart), 19'h1);
		rd(8'h07, 8'h4C);
		wr(8'h08, 8'hFF);
		rd(8'h33, 8'h00);
		ana.vbus_present = 1'b0;
		cyc(3);
		rd(8'h08, stat_exp());
		chk(19'(rdata_b), 19'(base_exp()));
		wr(8'h07, 8'h8C);
		rd(8'h07, 8'h0C);
		report_and_stop();
	end
endmodule
